// *** hw/tdm_loop_switch.sv ***
/*
 * Time-slot switch with control memory, one-frame data memories and the
 * RAM access schedule that fixes the frame delay of each connection.
 * Assumes the link clock, frame sync and serial inputs are asynchronous
 * and slow (at least eight system clocks per link bit).
 */
`default_nettype none

module tdm_loop_switch (
	input  wire logic                            clk_i,
	input  wire logic                            reset_n_i,
	input  wire logic [tdm_loop_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [tdm_loop_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                            wr_i,
	input  wire logic                            rd_i,
	output logic      [tdm_loop_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                            dcl_i,
	input  wire logic                            fsc_i,
	input  wire logic                            pcm_rxd_i,
	output logic                                 pcm_txd_o,
	output logic                                 pcm_txd_oe_o,
	input  wire logic                            cfi_du_i,
	output logic                                 cfi_dd_o,
	output logic                                 cfi_dd_oe_o
);

	localparam int SW = tdm_loop_pkg::SLOT_W;

	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic [3:0]  pin_meta_q;
	logic [3:0]  pin_sync_q;
	logic        dcl_prev_q;
	logic        edge_p;
	logic [7:0]  pos_q;
	logic [7:0]  cur_pos;
	logic [2:0]  period;
	logic [SW-1:0] slot;
	logic [7:0]  data_reg_q;
	logic [7:0]  addr_reg_q;
	logic [7:0]  ctrl_reg_q;
	logic [1:0]  mode_q;
	logic [7:0]  rdata_q;
	logic [11:0] cm_down_q [tdm_loop_pkg::SLOTS];
	logic [11:0] cm_up_q   [tdm_loop_pkg::SLOTS];
	logic [3:0]  ts_q      [tdm_loop_pkg::SLOTS];
	logic [7:0]  dm_down_q [tdm_loop_pkg::SLOTS];
	logic [7:0]  dm_up_q   [tdm_loop_pkg::SLOTS];
	logic [7:0]  pcm_sh_q;
	logic [7:0]  pcm_rx_q;
	logic [SW-1:0] pcm_rx_slot_q;
	logic        pcm_rx_pend_q;
	logic [7:0]  cfi_sh_q;
	logic [7:0]  cfi_rx_q;
	logic [SW-1:0] cfi_rx_slot_q;
	logic        cfi_rx_pend_q;
	logic [7:0]  cfi_buf_q [4];
	logic        cfi_en_q  [4];
	logic [7:0]  cfi_tx_q;
	logic        cfi_oe_q;
	logic [7:0]  pcm_buf_q [8];
	logic [3:0]  pcm_tsb_q [8];
	logic [7:0]  pcm_tx_q;
	logic [7:0]  pcm_mask_q;
	logic [7:0]  pcm_mask_new;
	logic [SW-1:0] blk_mask;
	logic        blk_start;
	logic        dd_now;
	logic        up_bit;
	logic [SW-1:0] cfi_tgt;
	logic [SW-1:0] pcm_tgt;
	logic [11:0] cm_tgt;
	logic [11:0] cm_in;
	logic [7:0]  cfi_src;

	// The reset is released through two flip-flops; everything else uses the copy.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pins cross in through two stages; only the second stage is read.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
			dcl_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= {cfi_du_i, pcm_rxd_i, fsc_i, dcl_i};
			pin_sync_q <= pin_meta_q;
			dcl_prev_q <= pin_sync_q[0];
		end
	end
	assign edge_p = pin_sync_q[0] & ~dcl_prev_q;

	// Frame position advances on each link clock rising edge; sync restarts it.
	assign cur_pos = pin_sync_q[1] ? 8'h00 : pos_q + 8'h01;
	assign period  = cur_pos[2:0];
	assign slot    = cur_pos[7:3];
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= 8'hFF;
		end else if (edge_p) begin
			pos_q <= cur_pos;
		end
	end

	// Software registers; a control write performs the memory access.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_reg_q <= tdm_loop_pkg::REG_RESET;
			addr_reg_q <= tdm_loop_pkg::REG_RESET;
			ctrl_reg_q <= tdm_loop_pkg::REG_RESET;
			mode_q     <= 2'h0;
		end else if (wr_i) begin
			if (addr_i == tdm_loop_pkg::REG_DATA) begin
				data_reg_q <= wdata_i;
			end else if (addr_i == tdm_loop_pkg::REG_ADDR) begin
				addr_reg_q <= wdata_i;
			end else if (addr_i == tdm_loop_pkg::REG_CTRL) begin
				ctrl_reg_q <= wdata_i;
			end else if (addr_i == tdm_loop_pkg::REG_MODE) begin
				mode_q <= wdata_i[1:0];
			end
		end
	end

	// Control and tristate memories, written only through the control register.
	// The access uses the data and address registers as they stand.
	assign cm_in = {wdata_i[tdm_loop_pkg::CODE_W-1:0], data_reg_q};
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < tdm_loop_pkg::SLOTS; i++) begin
				cm_down_q[i] <= 12'h000;
				cm_up_q[i]   <= 12'h000;
				ts_q[i]      <= 4'h0;
			end
		end else if (wr_i && addr_i == tdm_loop_pkg::REG_CTRL) begin
			if (wdata_i[7:tdm_loop_pkg::MOC_LSB] == tdm_loop_pkg::MOC_TRISTATE) begin
				ts_q[addr_reg_q[SW-1:0]] <= data_reg_q[3:0];
			end else if (wdata_i[7:tdm_loop_pkg::MOC_LSB] == tdm_loop_pkg::MOC_CM_WRITE) begin
				if (addr_reg_q[tdm_loop_pkg::DIR_BIT]) begin
					cm_up_q[addr_reg_q[SW-1:0]] <= cm_in;
				end else begin
					cm_down_q[addr_reg_q[SW-1:0]] <= cm_in;
				end
			end
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == tdm_loop_pkg::REG_DATA) begin
				rdata_q <= data_reg_q;
			end else if (addr_i == tdm_loop_pkg::REG_ADDR) begin
				rdata_q <= addr_reg_q;
			end else if (addr_i == tdm_loop_pkg::REG_CTRL) begin
				rdata_q <= ctrl_reg_q;
			end else if (addr_i == tdm_loop_pkg::REG_MODE) begin
				rdata_q <= {6'h00, mode_q};
			end else if (addr_i == tdm_loop_pkg::REG_POS) begin
				rdata_q <= pos_q;
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata_o = rdata_q;

	// Block start per highway mode; its first RAM period is no write cycle.
	always_comb begin
		if (mode_q == 2'h0) begin
			blk_mask = tdm_loop_pkg::BLK_M0;
		end else if (mode_q == 2'h1) begin
			blk_mask = tdm_loop_pkg::BLK_M1;
		end else begin
			blk_mask = tdm_loop_pkg::BLK_M2;
		end
	end
	assign blk_start = (slot & blk_mask) == 5'h00;

	// Highway receive: serial to parallel, then a pending byte awaits a write slot.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pcm_sh_q      <= 8'h00;
			pcm_rx_q      <= 8'h00;
			pcm_rx_slot_q <= 5'h00;
			pcm_rx_pend_q <= 1'b0;
		end else if (edge_p) begin
			pcm_sh_q <= {pcm_sh_q[6:0], pin_sync_q[2]};
			if (period == tdm_loop_pkg::LAST_BIT) begin
				pcm_rx_q      <= {pcm_sh_q[6:0], pin_sync_q[2]};
				pcm_rx_slot_q <= slot;
				pcm_rx_pend_q <= 1'b1;
			end else if (pcm_rx_pend_q && (period == tdm_loop_pkg::PCM_WR_P1
					|| (period == tdm_loop_pkg::PCM_WR_P0 && !blk_start))) begin
				pcm_rx_pend_q <= 1'b0;
			end
		end
	end

	// Downstream data memory holds exactly one frame, overwritten in place.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < tdm_loop_pkg::SLOTS; i++) begin
				dm_down_q[i] <= 8'h00;
			end
		end else if (edge_p && pcm_rx_pend_q && period != tdm_loop_pkg::PCM_WR_P2
				&& (period == tdm_loop_pkg::PCM_WR_P1
				|| (period == tdm_loop_pkg::PCM_WR_P0 && !blk_start))) begin
			dm_down_q[pcm_rx_slot_q] <= pcm_rx_q;
		end
	end

	// Internal downstream bit for the current position, and the looped input.
	assign dd_now = (period == 3'h0) ? cfi_buf_q[slot[1:0]][7] : cfi_tx_q[6];
	assign up_bit = (!cm_up_q[slot][tdm_loop_pkg::DIR_BIT]
		&& cm_up_q[slot][11:8] != tdm_loop_pkg::CODE_UNASSIGNED)
		? dd_now : pin_sync_q[3];

	// Interface receive: parallelise the (possibly looped) upstream bits.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfi_sh_q      <= 8'h00;
			cfi_rx_q      <= 8'h00;
			cfi_rx_slot_q <= 5'h00;
			cfi_rx_pend_q <= 1'b0;
		end else if (edge_p) begin
			cfi_sh_q <= {cfi_sh_q[6:0], up_bit};
			if (period == tdm_loop_pkg::LAST_BIT) begin
				cfi_rx_q      <= {cfi_sh_q[6:0], up_bit};
				cfi_rx_slot_q <= slot;
				cfi_rx_pend_q <= 1'b1;
			end else if (period == tdm_loop_pkg::CFI_WR_P) begin
				cfi_rx_pend_q <= 1'b0;
			end
		end
	end

	// Upstream data memory takes a whole byte for assigned slots only.
	assign cm_tgt = cm_up_q[cfi_rx_slot_q];
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < tdm_loop_pkg::SLOTS; i++) begin
				dm_up_q[i] <= 8'h00;
			end
		end else if (edge_p && cfi_rx_pend_q && period == tdm_loop_pkg::CFI_WR_P
				&& cm_tgt[11:8] != tdm_loop_pkg::CODE_UNASSIGNED) begin
			dm_up_q[cm_tgt[SW-1:0]] <= cfi_rx_q;
		end
	end

	// Interface fetch target: even slot in period 5, odd slot in period 6.
	assign cfi_tgt = slot + ((period == tdm_loop_pkg::CFI_RD_ODD)
		? tdm_loop_pkg::CFI_LEAD + 5'h01 : tdm_loop_pkg::CFI_LEAD);
	always_comb begin
		cfi_src = dm_down_q[cm_down_q[cfi_tgt][SW-1:0]];
		if (cm_down_q[cfi_tgt][tdm_loop_pkg::DIR_BIT]) begin
			cfi_src = dm_up_q[cm_down_q[cfi_tgt][SW-1:0]];
		end
	end

	// Fetch buffer of four slots; a slot's byte waits here until it is sent.
	// Reading early is what makes a late-written input slip a frame.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				cfi_buf_q[i] <= 8'h00;
				cfi_en_q[i]  <= 1'b0;
			end
		end else if (edge_p && slot[0] && (period == tdm_loop_pkg::CFI_RD_EVN
				|| period == tdm_loop_pkg::CFI_RD_ODD)) begin
			cfi_buf_q[cfi_tgt[1:0]] <= cfi_src;
			cfi_en_q[cfi_tgt[1:0]]  <= cm_down_q[cfi_tgt][11:8]
				!= tdm_loop_pkg::CODE_UNASSIGNED;
		end
	end

	// Interface transmit: load at slot start, shift out most significant bit first.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfi_tx_q <= 8'h00;
			cfi_oe_q <= 1'b0;
		end else if (edge_p) begin
			if (period == 3'h0) begin
				cfi_tx_q <= cfi_buf_q[slot[1:0]];
				cfi_oe_q <= cfi_en_q[slot[1:0]];
			end else begin
				cfi_tx_q <= {cfi_tx_q[6:0], 1'b0};
			end
		end
	end
	assign cfi_dd_o    = cfi_tx_q[7];
	assign cfi_dd_oe_o = cfi_oe_q;

	// Highway fetch runs four slots ahead from even slots, into an 8-entry buffer.
	assign pcm_tgt = slot + ((period == tdm_loop_pkg::PCM_RD_ODD)
		? tdm_loop_pkg::PCM_LEAD + 5'h01 : tdm_loop_pkg::PCM_LEAD);
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				pcm_buf_q[i] <= 8'h00;
				pcm_tsb_q[i] <= 4'h0;
			end
		end else if (edge_p && !slot[0] && (period == tdm_loop_pkg::PCM_RD_EVN
				|| period == tdm_loop_pkg::PCM_RD_ODD)) begin
			pcm_buf_q[pcm_tgt[2:0]] <= dm_up_q[pcm_tgt];
			pcm_tsb_q[pcm_tgt[2:0]] <= ts_q[pcm_tgt];
		end
	end

	// Each tristate field bit enables one pair of bits of the transmit slot.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ts_pair
			assign pcm_mask_new[2*g+1:2*g] = {2{pcm_tsb_q[slot[2:0]][g]}};
		end
	endgenerate

	// Highway transmit: the enable mask shifts with the data bits.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pcm_tx_q   <= 8'h00;
			pcm_mask_q <= 8'h00;
		end else if (edge_p) begin
			if (period == 3'h0) begin
				pcm_tx_q   <= pcm_buf_q[slot[2:0]];
				pcm_mask_q <= pcm_mask_new;
			end else begin
				pcm_tx_q   <= {pcm_tx_q[6:0], 1'b0};
				pcm_mask_q <= {pcm_mask_q[6:0], 1'b0};
			end
		end
	end
	assign pcm_txd_o    = pcm_tx_q[7];
	assign pcm_txd_oe_o = pcm_mask_q[7];

endmodule : tdm_loop_switch

`default_nettype wire

// *** inc/tdm_loop_pkg.sv ***
/*
 * Constants shared by the time-slot loop switch: register map, memory
 * operation and connection codes, field positions and slot timing.
 * Assumes one serial port on each side and a 32 slot frame of 8 bits.
 */
`default_nettype none

package tdm_loop_pkg;

	// Frame geometry.
	localparam int SLOT_W = 5;
	localparam int SLOTS  = 32;
	localparam int POS_W  = 8;

	// Register bus.
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_DATA = 3'h0;
	localparam logic [ADDR_W-1:0] REG_ADDR = 3'h1;
	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h2;
	localparam logic [ADDR_W-1:0] REG_MODE = 3'h3;
	localparam logic [ADDR_W-1:0] REG_POS  = 3'h4;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

	// Control register fields and codes.
	localparam int MOC_LSB = 4;
	localparam int CODE_W  = 4;
	localparam logic [3:0] MOC_CM_WRITE    = 4'h7;
	localparam logic [3:0] MOC_TRISTATE    = 4'h6;
	localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
	localparam logic [3:0] CODE_FULL       = 4'h1;

	// The top bit of a control memory address or pointer selects upstream (1) or downstream (0); tristate addresses ignore it.
	localparam int DIR_BIT = 7;

	// Internal RAM clock periods within a slot.
	localparam logic [2:0] PCM_WR_P0  = 3'h0;
	localparam logic [2:0] PCM_WR_P1  = 3'h4;
	localparam logic [2:0] PCM_WR_P2  = 3'h7;
	localparam logic [2:0] CFI_RD_EVN = 3'h5;
	localparam logic [2:0] CFI_RD_ODD = 3'h6;
	localparam logic [2:0] CFI_WR_P   = 3'h1;
	localparam logic [2:0] PCM_RD_EVN = 3'h4;
	localparam logic [2:0] PCM_RD_ODD = 3'h7;
	localparam logic [2:0] LAST_BIT   = 3'h7;

	// Fetch lead in slots for each output side.
	localparam logic [SLOT_W-1:0] CFI_LEAD = 5'h03;
	localparam logic [SLOT_W-1:0] PCM_LEAD = 5'h04;

	// Block-start masks on the slot number for PCM modes 0, 1 and 2.
	localparam logic [SLOT_W-1:0] BLK_M0 = 5'h01;
	localparam logic [SLOT_W-1:0] BLK_M1 = 5'h03;
	localparam logic [SLOT_W-1:0] BLK_M2 = 5'h07;

endpackage : tdm_loop_pkg

`default_nettype wire

// *** verification/link_model.sv ***
/* Far side model: highway and interface serial ports sharing one frame.
 * Assumes outputs settle within half a link bit after the rising edge. */
`default_nettype none
module link_model (
	output logic      dcl_o,
	output logic      fsc_o,
	output logic      pcm_rxd_o,
	output logic      cfi_du_o,
	input  wire logic pcm_txd_i,
	input  wire logic pcm_txd_oe_i,
	input  wire logic cfi_dd_i,
	input  wire logic cfi_dd_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rx_pcm[32], rx_cfi[32], tx_d[32], tx_e[32], dd_d[32], dd_e[32];
	logic [7:0] sd, se, cd, ce;
	int         pos, slot;
	event       slot_ev;

	// Bits change on the falling edge and are captured on it, MSB first.
	// The bench loads the receive bytes at time zero; clearing them here would race it.
	initial begin
		{dcl_o, fsc_o, pcm_rxd_o, cfi_du_o} = 4'h0;
		pos = 255;
		#13.7;
		forever begin
			pos = (pos + 1) % 256;
			fsc_o = (pos == 0);
			pcm_rxd_o = rx_pcm[pos / 8][7 - pos % 8];
			cfi_du_o = rx_cfi[pos / 8][7 - pos % 8];
			#40 dcl_o = 1'b1;
			#40 dcl_o = 1'b0;
			sd = {sd[6:0], pcm_txd_i};
			se = {se[6:0], pcm_txd_oe_i};
			cd = {cd[6:0], cfi_dd_i};
			ce = {ce[6:0], cfi_dd_oe_i};
			if (pos % 8 == 7) begin
				slot = pos / 8;
				{tx_d[slot], tx_e[slot], dd_d[slot], dd_e[slot]} = {sd, se, cd, ce};
				->slot_ev;
			end
		end
	end
endmodule : link_model
`default_nettype wire

// *** verification/tb_tdm_loop_switch.sv ***
/* Self-checking bench: registers, full channel, both loop kinds, tristate.
 * Assumes memories clear on reset and constant slot bytes every frame. */
`default_nettype none
module tb_tdm_loop_switch;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int side; int slot; logic [7:0] d; logic [7:0] e;} note_s;
	logic       clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, code;
	logic       dcl_i, fsc_i, pcm_rxd_i, pcm_txd_o, pcm_txd_oe_o, cfi_du_i, cfi_dd_o, cfi_dd_oe_o;
	logic [7:0] rd_exp[$];
	note_s      sl_q[$], n;
	int         fails = 0, compares = 0;

	always #2.5 clk_i = ~clk_i;

	tdm_loop_switch tdm_loop_switch_i (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .dcl_i, .fsc_i, .pcm_rxd_i, .pcm_txd_o, .pcm_txd_oe_o, .cfi_du_i,
		.cfi_dd_o, .cfi_dd_oe_o);
	link_model link_model_i (.dcl_o(dcl_i), .fsc_o(fsc_i), .pcm_rxd_o(pcm_rxd_i),
		.cfi_du_o(cfi_du_i), .pcm_txd_i(pcm_txd_o), .pcm_txd_oe_i(pcm_txd_oe_o),
		.cfi_dd_i(cfi_dd_o), .cfi_dd_oe_i(cfi_dd_oe_o));

	task automatic cmp_rd(input logic [7:0] x, input logic [7:0] g);
		compares++;
		if (g !== x) begin
			fails++;
			$display("ERROR rdata expected %h seen %h", x, g);
		end
	endtask : cmp_rd

	// Data is only judged on bits the enable says are driven.
	task automatic cmp_slot(input note_s x, input logic [7:0] d, input logic [7:0] e);
		compares++;
		if (e !== x.e || (d & x.e) !== (x.d & x.e)) begin
			fails++;
			$display("ERROR side %0d slot %0d expected %h/%h seen %h/%h",
				x.side, x.slot, x.d, x.e, d, e);
		end
	endtask : cmp_slot

	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{wr_i, rd_i, addr_i, wdata_i} <= {1'b1, 1'b0, a, d};
	endtask : bus_wr

	task automatic bus_rd(input logic [2:0] a, input logic [7:0] x);
		@(posedge clk_i);
		{wr_i, rd_i, addr_i} <= {1'b0, 1'b1, a};
		rd_exp.push_back(x);
	endtask : bus_rd

	task automatic bus_idle();
		@(posedge clk_i);
		{wr_i, rd_i} <= 2'b00;
	endtask : bus_idle

	// Data and address first; the control write starts the access.
	task automatic prog_entry(input logic [7:0] a, input logic [7:0] p, input logic [7:0] c);
		bus_wr(tdm_loop_pkg::REG_DATA, p);
		bus_wr(tdm_loop_pkg::REG_ADDR, a);
		bus_wr(tdm_loop_pkg::REG_CTRL, c);
	endtask : prog_entry

	task automatic note(input int s, input int t, input logic [7:0] d, input logic [7:0] e);
		sl_q.push_back('{s, t, d, e});
	endtask : note

	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	// Read answers stand only in the cycle after the strobe.
	always @(posedge clk_i) begin
		rd_q <= rd_i;
		if (rd_q) cmp_rd(rd_exp.pop_front(), rdata_o);
	end

	// Side 0 is the interface output, side 1 the highway output.
	always @(link_model_i.slot_ev) begin
		while (sl_q.size() > 0 && sl_q[0].slot == link_model_i.slot) begin
			n = sl_q.pop_front();
			if (n.side == 0) cmp_slot(n, link_model_i.dd_d[n.slot], link_model_i.dd_e[n.slot]);
			else cmp_slot(n, link_model_i.tx_d[n.slot], link_model_i.tx_e[n.slot]);
		end
	end

	initial begin
		void'($urandom(32'h2cdf));
		for (int i = 0; i < 32; i++) begin
			link_model_i.rx_pcm[i] = 8'($urandom);
			link_model_i.rx_cfi[i] = 8'($urandom);
		end
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		bus_wr(tdm_loop_pkg::REG_DATA, 8'hA5);
		bus_rd(tdm_loop_pkg::REG_DATA, 8'hA5);
		bus_wr(tdm_loop_pkg::REG_ADDR, 8'h9C);
		bus_rd(tdm_loop_pkg::REG_ADDR, 8'h9C);
		bus_wr(3'h6, 8'hFF);
		bus_rd(3'h6, 8'h00);
		bus_rd(3'h5, 8'h00);
		// Highway mode 1 moves the block starts; the switched bytes must not change.
		bus_wr(tdm_loop_pkg::REG_MODE, 8'h01);
		bus_rd(tdm_loop_pkg::REG_MODE, 8'h01);
		// Subchannel codes act as a full byte in this build.
		code = {tdm_loop_pkg::MOC_CM_WRITE, 4'(1 + $urandom % 7)};
		prog_entry(8'h02, 8'h03, {tdm_loop_pkg::MOC_CM_WRITE, tdm_loop_pkg::CODE_FULL});
		prog_entry(8'h84, 8'h80, {tdm_loop_pkg::MOC_CM_WRITE, tdm_loop_pkg::CODE_FULL});
		prog_entry(8'h07, 8'h80, code);
		prog_entry(8'h80, 8'h00, {tdm_loop_pkg::MOC_TRISTATE, 4'h0});
		prog_entry(8'h0A, 8'h0D, {tdm_loop_pkg::MOC_CM_WRITE, tdm_loop_pkg::CODE_UNASSIGNED});
		prog_entry(8'h8A, 8'h05, {tdm_loop_pkg::MOC_CM_WRITE, tdm_loop_pkg::CODE_FULL});
		prog_entry(8'h85, 8'h0F, {tdm_loop_pkg::MOC_TRISTATE, 4'h0});
		prog_entry(8'h86, 8'h05, {tdm_loop_pkg::MOC_TRISTATE, 4'h0});
		bus_rd(tdm_loop_pkg::REG_CTRL, {tdm_loop_pkg::MOC_TRISTATE, 4'h0});
		bus_idle();
		// Up to two frames of switching delay, plus one to settle.
		repeat (3 * 4096) @(posedge clk_i);
		note(1, 0, 8'h00, 8'h00);
		note(0, 2, link_model_i.rx_pcm[3], 8'hFF);
		note(1, 3, 8'h00, 8'h00);
		note(1, 5, link_model_i.rx_pcm[13], 8'hFF);
		note(1, 6, 8'h00, 8'h33);
		note(0, 7, link_model_i.rx_cfi[4], 8'hFF);
		note(0, 10, 8'h00, 8'h00);
		for (int i = 0; i < 2 * 4096 && sl_q.size() > 0; i++) @(posedge clk_i);
		if (sl_q.size() > 0) begin
			fails++;
			$display("ERROR slot notes left expected 0 seen %0d", sl_q.size());
		end
		results();
	end
endmodule : tb_tdm_loop_switch

bind tdm_loop_switch tdm_loop_switch_assertions tdm_loop_switch_assertions_i (.clk_i,
	.reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .dcl_i, .fsc_i, .pcm_txd_o,
	.pcm_txd_oe_o, .cfi_dd_o, .cfi_dd_oe_o);
`default_nettype wire

// *** verification/tdm_loop_switch_assertions.sv ***
/* Concurrent checks on the ports of the time-slot loop switch.
 * Assumes the link clock is slower than eight system clocks per bit. */
`default_nettype none
module tdm_loop_switch_assertions (
	input wire logic                            clk_i,
	input wire logic                            reset_n_i,
	input wire logic [tdm_loop_pkg::ADDR_W-1:0] addr_i,
	input wire logic [tdm_loop_pkg::DATA_W-1:0] wdata_i,
	input wire logic                            wr_i,
	input wire logic                            rd_i,
	input wire logic [tdm_loop_pkg::DATA_W-1:0] rdata_o,
	input wire logic                            dcl_i,
	input wire logic                            fsc_i,
	input wire logic                            pcm_txd_o,
	input wire logic                            pcm_txd_oe_o,
	input wire logic                            cfi_dd_o,
	input wire logic                            cfi_dd_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       dcl_q;
	logic [3:0] since_q;
	logic [7:0] pos_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Own frame position and cycles since the last link edge; raw sampling is fine here.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dcl_q   <= 1'b0;
			since_q <= 4'hF;
			pos_q   <= 8'h00;
		end else begin
			dcl_q <= dcl_i;
			if (dcl_i && !dcl_q) begin
				since_q <= 4'h0;
				pos_q   <= fsc_i ? 8'h00 : pos_q + 8'h01;
			end else if (since_q != 4'hF) begin
				since_q <= since_q + 4'h1;
			end
		end
	end

	sequence s_wr_rd(logic [tdm_loop_pkg::ADDR_W-1:0] a);
		wr_i && addr_i == a ##1 rd_i && addr_i == a;
	endsequence

	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	a_unmapped_read: assert property (rd_i && addr_i > 3'h4 |=> rdata_o == 8'h00)
		else $error("unmapped read returned data");
	a_data_readback: assert property (
		s_wr_rd(tdm_loop_pkg::REG_DATA) |=> rdata_o == $past(wdata_i, 2))
		else $error("data register readback wrong");
	a_addr_readback: assert property (
		s_wr_rd(tdm_loop_pkg::REG_ADDR) |=> rdata_o == $past(wdata_i, 2))
		else $error("address register readback wrong");
	a_dd_bit_timing: assert property ($changed(cfi_dd_o) |-> since_q <= 4'h7)
		else $error("interface output moved away from a link edge");
	a_txd_bit_timing: assert property ($changed(pcm_txd_o) |-> since_q <= 4'h7)
		else $error("highway output moved away from a link edge");
	a_dd_oe_slot: assert property (
		$changed(cfi_dd_oe_o) |-> since_q <= 4'h7 && pos_q[2:0] == 3'h0)
		else $error("interface enable changed inside a slot");
	a_txd_oe_pair: assert property (
		$changed(pcm_txd_oe_o) |-> since_q <= 4'h7 && !pos_q[0])
		else $error("highway enable changed inside a bit pair");
endmodule : tdm_loop_switch_assertions
`default_nettype wire
